// File: core/vcu_pkg.sv
package vcu_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] MODE_OFFSET = 4'h4;
    localparam logic [3:0] INTCFG_OFFSET = 4'h8;

    // ==========================================================
    // Control register field positions
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_OUT_BIT = 6;
    localparam int CTRL_RIF_BIT = 5;
    localparam int CTRL_FIF_BIT = 4;
    localparam int CTRL_HYP_LSB = 2;
    localparam int CTRL_HYN_LSB = 0;

    // ==========================================================
    // Mode register field positions
    localparam int MODE_RSV_BIT = 7;
    localparam int MODE_RIE_BIT = 5;
    localparam int MODE_FIE_BIT = 4;
    localparam int MODE_MD_LSB = 0;

    // ==========================================================
    // Interrupt source config field positions
    localparam int INTCFG_SRC_BIT = 0;
    localparam int INTCFG_GLB_BIT = 1;

    // ==========================================================
    // Reset values
    localparam logic [1:0] HYST_RESET = 2'h0;
    localparam logic [1:0] MODE_RESET = 2'h2;
    localparam logic [1:0] SYNC_RESET = 2'h0;

    // ==========================================================
    // Response modes and hysteresis codes
    typedef enum logic [1:0] {
        RESP_FAST = 2'b00,
        RESP_MODE1 = 2'b01,
        RESP_MODE2 = 2'b10,
        RESP_LOWPWR = 2'b11
    } vcu_resp_t;

    typedef enum logic [1:0] {
        HYST_OFF = 2'b00,
        HYST_LVL1 = 2'b01,
        HYST_LVL2 = 2'b10,
        HYST_MAX = 2'b11
    } vcu_hyst_t;

    // ==========================================================
    // AXI responses
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

endpackage : vcu_pkg

// File: core/vcu_voltage_comparator_unit.sv
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
// Operation
// RL1 - Enabled: output one when positive exceeds negative
// RL2 - Disabled: comparison result forced to zero
// RL3 - Synchronised output readable, interrupt source, pin
// RL4 - Raw output unsynchronised, valid without clock
// RL5 - Rising and falling edges in separate flags
// RL6 - Flags set regardless of interrupt enables
// RL7 - Flags stay set until software clears
// RL8 - Separate rise and fall interrupt enables
// RL9 - Request needs flag, enable, source, global
// RL10 - Four response modes, slower uses less power
// RL11 - Disabled comparator enters low power shutdown
// RL12 - Hysteresis delays transitions by programmed amount
// RL13 - Independent positive/negative hysteresis: 20,10,5,0 mV
// RL14 - Software enables before use; clearing disables
// RL15 - Software clears flags after settings change
// RL16 - Hysteresis code 00 off, 11 maximum
// RL17 - Mode code 00 fastest, 11 slowest
// RL18 - Flag zero means no edge since clear
// RL19 - Edge from current versus previous sample
// RL20 - Two flip-flops before synchronised output use
module vcu_voltage_comparator_unit
    import vcu_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite slave
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Analog core
    input wire logic analogCompare,
    output logic analogEnable,
    output logic [1:0] analogRespMode,
    output logic [1:0] analogPosHyst,
    output logic [1:0] analogNegHyst,
    // Raw and synchronised outputs
    output logic rawCompareOut,
    output logic syncCompareOut,
    // Interrupt request to CPU handler
    output logic compareIrq
);

    // ==========================================================
    // Registers
    logic compareEnable_ff;
    logic [1:0] posHystSel_ff;
    logic [1:0] negHystSel_ff;
    logic [1:0] respMode_ff;
    logic riseIrqEnable_ff;
    logic fallIrqEnable_ff;
    logic irqSourceEn_ff;
    logic globalIrqEn_ff;
    logic riseEdgeFlag_ff;
    logic fallEdgeFlag_ff;
    logic [1:0] sync_ff;
    logic prevSample_ff;
    logic syncOut_ff;
    logic irq_ff;
    logic analogEnable_ff;
    logic [1:0] analogRespMode_ff;
    logic [1:0] analogPosHyst_ff;
    logic [1:0] analogNegHyst_ff;

    // ==========================================================
    // Raw path, combinational, no clock needed
    always_comb begin
        rawCompareOut = analogCompare & analogEnable_ff; // [RL1] [RL2] [RL4]
    end

    // ==========================================================
    // Synchroniser
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_ff <= SYNC_RESET;
        end else begin
            sync_ff <= {sync_ff[0], rawCompareOut}; // [RL20]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            syncOut_ff <= 1'b0;
            prevSample_ff <= 1'b0;
        end else begin
            syncOut_ff <= sync_ff[1]; // [RL3]
            prevSample_ff <= syncOut_ff;
        end
    end

    // ==========================================================
    // Edge detection
    logic riseEvent;
    logic fallEvent;
    always_comb begin
        riseEvent = syncOut_ff & ~prevSample_ff; // [RL19] [RL5]
        fallEvent = ~syncOut_ff & prevSample_ff; // [RL19] [RL5]
    end

    // ==========================================================
    // AXI4-Lite write channel
    logic awHeld_ff;
    logic wHeld_ff;
    logic [3:0] awAddr_ff;
    logic [31:0] wData_ff;
    logic [3:0] wStrb_ff;
    logic doWrite;
    logic writeCtrl;
    logic writeMode;
    logic writeIntcfg;

    always_comb begin
        doWrite = awHeld_ff & wHeld_ff & ~s_axi_bvalid;
        writeCtrl = doWrite & (awAddr_ff == CTRL_OFFSET) & wStrb_ff[0];
        writeMode = doWrite & (awAddr_ff == MODE_OFFSET) & wStrb_ff[0];
        writeIntcfg = doWrite & (awAddr_ff == INTCFG_OFFSET) & wStrb_ff[0];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            awHeld_ff <= 1'b0;
            awAddr_ff <= 4'h0;
        end else if (s_axi_awvalid & s_axi_awready) begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= {s_axi_awaddr[3:2], 2'b00};
        end else if (doWrite) begin
            awHeld_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wHeld_ff <= 1'b0;
            wData_ff <= 32'h0;
            wStrb_ff <= 4'h0;
        end else if (s_axi_wvalid & s_axi_wready) begin
            wHeld_ff <= 1'b1;
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
        end else if (doWrite) begin
            wHeld_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= ~awHeld_ff & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
            s_axi_wready <= ~wHeld_ff & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AXI_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awAddr_ff == CTRL_OFFSET || awAddr_ff == MODE_OFFSET
                || awAddr_ff == INTCFG_OFFSET) ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Configuration registers
    always_ff @(posedge clk) begin
        if (rst) begin
            compareEnable_ff <= 1'b0;
            posHystSel_ff <= HYST_RESET;
            negHystSel_ff <= HYST_RESET;
        end else if (writeCtrl) begin
            compareEnable_ff <= wData_ff[CTRL_EN_BIT]; // [RL14] [RL11]
            posHystSel_ff <= wData_ff[CTRL_HYP_LSB +: 2]; // [RL13] [RL16]
            negHystSel_ff <= wData_ff[CTRL_HYN_LSB +: 2]; // [RL13] [RL16]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            respMode_ff <= MODE_RESET;
            riseIrqEnable_ff <= 1'b0;
            fallIrqEnable_ff <= 1'b0;
        end else if (writeMode) begin
            respMode_ff <= wData_ff[MODE_MD_LSB +: 2]; // [RL10] [RL17]
            riseIrqEnable_ff <= wData_ff[MODE_RIE_BIT]; // [RL8]
            fallIrqEnable_ff <= wData_ff[MODE_FIE_BIT]; // [RL8]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irqSourceEn_ff <= 1'b0;
            globalIrqEn_ff <= 1'b0;
        end else if (writeIntcfg) begin
            irqSourceEn_ff <= wData_ff[INTCFG_SRC_BIT];
            globalIrqEn_ff <= wData_ff[INTCFG_GLB_BIT];
        end
    end

    // ==========================================================
    // Edge flags, set wins over software clear
    always_ff @(posedge clk) begin
        if (rst) begin
            riseEdgeFlag_ff <= 1'b0;
            fallEdgeFlag_ff <= 1'b0;
        end else begin
            if (riseEvent) begin
                riseEdgeFlag_ff <= 1'b1; // [RL6] [RL18]
            end else if (writeCtrl) begin
                riseEdgeFlag_ff <= wData_ff[CTRL_RIF_BIT]; // [RL7]
            end
            if (fallEvent) begin
                fallEdgeFlag_ff <= 1'b1; // [RL6] [RL18]
            end else if (writeCtrl) begin
                fallEdgeFlag_ff <= wData_ff[CTRL_FIF_BIT]; // [RL7]
            end
        end
    end

    // ==========================================================
    // Interrupt request
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= ((riseEdgeFlag_ff & riseIrqEnable_ff)
                | (fallEdgeFlag_ff & fallIrqEnable_ff))
                & irqSourceEn_ff & globalIrqEn_ff; // [RL9] [RL8]
        end
    end

    // ==========================================================
    // Analog core control
    always_ff @(posedge clk) begin
        if (rst) begin
            analogEnable_ff <= 1'b0;
            analogRespMode_ff <= MODE_RESET;
            analogPosHyst_ff <= HYST_RESET;
            analogNegHyst_ff <= HYST_RESET;
        end else begin
            analogEnable_ff <= compareEnable_ff; // [RL11]
            analogRespMode_ff <= respMode_ff; // [RL10]
            analogPosHyst_ff <= posHystSel_ff; // [RL12]
            analogNegHyst_ff <= negHystSel_ff; // [RL12]
        end
    end

    // ==========================================================
    // AXI4-Lite read channel
    logic [31:0] readWord;
    logic readHit;
    always_comb begin
        readWord = 32'h0;
        readHit = 1'b1;
        case ({s_axi_araddr[3:2], 2'b00})
            CTRL_OFFSET: begin
                readWord[CTRL_EN_BIT] = compareEnable_ff;
                readWord[CTRL_OUT_BIT] = syncOut_ff; // [RL3]
                readWord[CTRL_RIF_BIT] = riseEdgeFlag_ff;
                readWord[CTRL_FIF_BIT] = fallEdgeFlag_ff;
                readWord[CTRL_HYP_LSB +: 2] = posHystSel_ff;
                readWord[CTRL_HYN_LSB +: 2] = negHystSel_ff;
            end
            MODE_OFFSET: begin
                readWord[MODE_RSV_BIT] = 1'b1;
                readWord[MODE_RIE_BIT] = riseIrqEnable_ff;
                readWord[MODE_FIE_BIT] = fallIrqEnable_ff;
                readWord[MODE_MD_LSB +: 2] = respMode_ff;
            end
            INTCFG_OFFSET: begin
                readWord[INTCFG_SRC_BIT] = irqSourceEn_ff;
                readWord[INTCFG_GLB_BIT] = globalIrqEn_ff;
            end
            default: begin
                readHit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= AXI_OKAY;
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= readWord;
            s_axi_rresp <= readHit ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // ==========================================================
    // Outputs
    always_comb begin
        syncCompareOut = syncOut_ff;
        compareIrq = irq_ff;
        analogEnable = analogEnable_ff;
        analogRespMode = analogRespMode_ff;
        analogPosHyst = analogPosHyst_ff;
        analogNegHyst = analogNegHyst_ff;
    end

endmodule : vcu_voltage_comparator_unit

// File: test/vcu_analog_model.sv
`timescale 1ns/10ps
module vcu_analog_model (
    input wire logic clk,
    input wire logic analogEnable,
    input wire logic posAboveNeg,
    output logic analogCompare
);
    logic junk_ff = 1'b0;
    always @(posedge clk) begin
        junk_ff <= ~junk_ff;
    end
    // Shut down core gives no valid level
    assign analogCompare = analogEnable ? posAboveNeg : junk_ff;
endmodule : vcu_analog_model

// File: test/vcu_asserts.sv
`timescale 1ns/10ps
module vcu_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic analogCompare,
    input wire logic analogEnable,
    input wire logic [1:0] analogRespMode,
    input wire logic rawCompareOut,
    input wire logic syncCompareOut
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence wrTake;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    raw_gate_a: assert property (rawCompareOut == (analogCompare && analogEnable))
        else $error("raw output not gated");
    sync_delay_a: assert property (syncCompareOut == $past(rawCompareOut, 3))
        else $error("sync output delay wrong");
    off_zero_a: assert property (!analogEnable [*3] |=> !syncCompareOut)
        else $error("sync output high while off");
    wr_resp_a: assert property (wrTake |-> ##2 s_axi_bvalid)
        else $error("write response late");
    wr_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    cfg_stable_a: assert property (!($past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
        |-> $stable(analogEnable) && $stable(analogRespMode))
        else $error("config changed without write");
endmodule : vcu_checker
bind vcu_voltage_comparator_unit vcu_checker u_vcu_checker (.*);

// File: test/vcu_voltage_comparator_unit_tb.sv
`timescale 1ns/10ps
module vcu_voltage_comparator_unit_tb
    import vcu_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, posAboveNeg = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, analogRespMode, analogPosHyst, analogNegHyst;
    logic analogCompare, analogEnable, rawCompareOut, syncCompareOut, compareIrq;
    int errCount = 0, samplesChecked = 0, cycles = 0;

    vcu_voltage_comparator_unit u_vcu_voltage_comparator_unit (.*);
    vcu_analog_model u_vcu_analog_model (.*);

    always #12.5 clk = ~clk;

    // ==========================================================
    // Access tasks
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samplesChecked++;
        if (s !== e) begin
            errCount++;
            $display("[ERR] %0t got %h exp %h", $time, s, e);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rresp, er);
        if (er === AXI_OKAY) chk(s_axi_rdata, {24'h0, d});
    endtask : rd

    task automatic settle();
        repeat (6) @(posedge clk);
    endtask : settle

    task automatic stopTest();
        $display("checks %0d errors %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stopTest

    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            errCount++;
            stopTest();
        end
    end

    // ==========================================================
    // Tests
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(CTRL_OFFSET, 8'h00, AXI_OKAY);
        rd(MODE_OFFSET, 8'h82, AXI_OKAY);
        rd(INTCFG_OFFSET, 8'h00, AXI_OKAY);
        rd(4'hC, 8'h00, AXI_SLVERR);
        wr(4'hC, 8'hFF, AXI_SLVERR);
        for (int i = 0; i < 4; i++) begin
            wr(CTRL_OFFSET, {4'h8, i[1:0], ~i[1:0]}, AXI_OKAY);
            wr(MODE_OFFSET, {6'h28, i[1:0]}, AXI_OKAY);
            @(posedge clk);
            chk(analogPosHyst, i[1:0]);
            chk(analogNegHyst, {~i[1:0]});
            chk(analogRespMode, i[1:0]);
        end
        chk(analogEnable, 1'b1);
        wr(CTRL_OFFSET, 8'h80, AXI_OKAY);
        posAboveNeg <= 1'b1;
        settle();
        chk(rawCompareOut, 1'b1);
        chk(syncCompareOut, 1'b1);
        chk(compareIrq, 1'b0);
        rd(CTRL_OFFSET, 8'hE0, AXI_OKAY);
        wr(INTCFG_OFFSET, 8'h01, AXI_OKAY);
        settle();
        chk(compareIrq, 1'b0);
        wr(INTCFG_OFFSET, 8'h03, AXI_OKAY);
        settle();
        chk(compareIrq, 1'b1);
        posAboveNeg <= 1'b0;
        settle();
        rd(CTRL_OFFSET, 8'hB0, AXI_OKAY);
        wr(CTRL_OFFSET, 8'h90, AXI_OKAY);
        settle();
        chk(compareIrq, 1'b0);
        wr(MODE_OFFSET, 8'h93, AXI_OKAY);
        settle();
        chk(compareIrq, 1'b1);
        rd(MODE_OFFSET, 8'h93, AXI_OKAY);
        wr(INTCFG_OFFSET, 8'h01, AXI_OKAY);
        settle();
        chk(compareIrq, 1'b0);
        posAboveNeg <= 1'b1;
        settle();
        wr(CTRL_OFFSET, 8'h00, AXI_OKAY);
        settle();
        chk(analogEnable, 1'b0);
        chk(rawCompareOut, 1'b0);
        rd(CTRL_OFFSET, 8'h10, AXI_OKAY);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(CTRL_OFFSET, 8'h00, AXI_OKAY);
        stopTest();
    end
endmodule : vcu_voltage_comparator_unit_tb
